// ===== design/signed_divide_pkg.sv
// Constants and types of the signed register divide unit.
// Assumes one machine state equals one clk cycle (10 MHz, 100 ns).
`default_nettype none

package signed_divide_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int unsigned IDX_W  = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 6;

  // ************************************************************
  // Machine state counts, one clk cycle each
  // ************************************************************
  localparam logic [CNT_W-1:0] STATES_EVEN  = 6'h28;
  localparam logic [CNT_W-1:0] STATES_ODD   = 6'h27;
  localparam logic [CNT_W-1:0] STATES_MINQ  = 6'h29;
  localparam logic [CNT_W-1:0] STATES_EARLY = 6'h07;
  localparam logic [CNT_W-1:0] SLOW_EXTRA   = 6'h03;
  localparam logic [CNT_W-1:0] DIV_STEPS    = 6'h20;

  // ************************************************************
  // Values
  // ************************************************************
  localparam logic [DATA_W-1:0] MIN_QUOTIENT    = 32'h8000_0000;
  localparam logic [DATA_W-1:0] DATA_RESET      = 32'h0000_0000;
  localparam logic [IDX_W-1:0]  IDX_RESET       = 4'h0;
  localparam logic [CNT_W-1:0]  CNT_RESET       = 6'h00;
  localparam logic [3:0]        FLAG_WRITE_MASK = 4'hB;
  localparam logic [3:0]        FLAG_MASK_RESET = 4'h0;

  // Gray-coded control states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } ctrl_state_type;

endpackage : signed_divide_pkg

`default_nettype wire

// ===== design/div_if.sv
// Carrier between the divide controller and its magnitude divider.
// Assumes both ends share clk and rst_b.
`default_nettype none

interface div_if;
  logic        start;
  logic [31:0] hiMag;
  logic [31:0] loMag;
  logic [31:0] divisor;
  logic        busy;
  logic [31:0] quotient;
  logic [31:0] remainder;

  modport ctrl (output start, hiMag, loMag, divisor,
                input  busy, quotient, remainder);
  modport unit (input  start, hiMag, loMag, divisor,
                output busy, quotient, remainder);
endinterface : div_if

`default_nettype wire

// ===== design/magnitude_divider.sv
// Unsigned restoring divider, one quotient bit per clk.
// Assumes the high dividend half is below the divisor at start.
`default_nettype none

module magnitude_divider
  import signed_divide_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Controller side
  div_if.unit      bus
);

  // ************************************************************
  // Iteration state
  // ************************************************************
  logic [31:0]      remReg, remNext;
  logic [31:0]      shReg, shNext;
  logic [31:0]      dvsReg, dvsNext;
  logic [CNT_W-1:0] stepReg, stepNext;
  logic             runReg, runNext;
  logic [32:0]      trial;
  logic [32:0]      diff;

  // One restoring step per cycle; results hold after the last
  always_comb begin
    remNext  = remReg;
    shNext   = shReg;
    dvsNext  = dvsReg;
    stepNext = stepReg;
    runNext  = runReg;
    trial    = {remReg, shReg[31]};
    diff     = trial - {1'b0, dvsReg};
    if (bus.start) begin
      remNext  = bus.hiMag;
      shNext   = bus.loMag;
      dvsNext  = bus.divisor;
      stepNext = CNT_RESET;
      runNext  = 1'b1;
    end else if (runReg) begin
      // Borrow out of diff means trial is still below the divisor
      if (!diff[32]) begin
        remNext = diff[31:0];
      end else begin
        remNext = trial[31:0];
      end
      shNext   = {shReg[30:0], ~diff[32]};
      stepNext = stepReg + 6'h01;
      if (stepReg == DIV_STEPS - 6'h01) begin
        runNext = 1'b0;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      remReg  <= DATA_RESET;
      shReg   <= DATA_RESET;
      dvsReg  <= DATA_RESET;
      stepReg <= CNT_RESET;
      runReg  <= 1'b0;
    end else begin
      remReg  <= remNext;
      shReg   <= shNext;
      dvsReg  <= dvsNext;
      stepReg <= stepNext;
      runReg  <= runNext;
    end
  end

  assign bus.busy      = runReg;
  assign bus.quotient  = shReg;
  assign bus.remainder = remReg;

endmodule : magnitude_divider

`default_nettype wire

// ===== design/signed_register_divider.sv
// Signed register divide execution unit with timed completion.
// Assumes the core supplies operands from one register file with start
// and applies the write-back pulses and the held flags when done is high.
`default_nettype none

module signed_register_divider
  import signed_divide_pkg::*;
(
  // Clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 rst_b,
  // Issue
  input  wire logic                                 start,
  input  wire logic [signed_divide_pkg::IDX_W-1:0]  destIndex,
  input  wire logic                                 fileSel,
  input  wire logic                                 slowTiming,
  input  wire logic [signed_divide_pkg::DATA_W-1:0] destValue,
  input  wire logic [signed_divide_pkg::DATA_W-1:0] destNextValue,
  input  wire logic [signed_divide_pkg::DATA_W-1:0] srcValue,
  // Status
  output logic                                      busy,
  output logic                                      done,
  // Write-back
  output logic                                      wrFile,
  output logic                                      wrEnable,
  output logic [signed_divide_pkg::IDX_W-1:0]       wrIndex,
  output logic [signed_divide_pkg::DATA_W-1:0]      wrData,
  output logic                                      wr2Enable,
  output logic [signed_divide_pkg::IDX_W-1:0]       wr2Index,
  output logic [signed_divide_pkg::DATA_W-1:0]      wr2Data,
  // Flags
  output logic                                      nFlag,
  output logic                                      zFlag,
  output logic                                      vFlag,
  output logic [3:0]                                flagWriteMask
);

  import signed_divide_pkg::*;

  // ************************************************************
  // Operand preparation
  // ************************************************************
  div_if divBus ();

  // Declared early: the issue gate reads the state
  ctrl_state_type stateReg, stateNext;
  logic        accept;
  logic        oddDest;
  logic        dvdSign;
  logic [63:0] dvd64;
  logic [63:0] dvdMag;
  logic [31:0] rsMag;
  logic        divZero;
  logic        earlyNow;

  // Odd destination sign-extends so both cases share one divider
  always_comb begin
    oddDest = destIndex[0];
    dvdSign = destValue[31];
    if (oddDest) begin
      dvd64 = {{32{dvdSign}}, destValue};
    end else begin
      dvd64 = {destValue, destNextValue};
    end
    dvdMag  = dvdSign ? 64'(64'h0 - dvd64) : dvd64;
    rsMag   = srcValue[31] ? 32'(32'h0 - srcValue) : srcValue;
    divZero = (srcValue == DATA_RESET);
    // High half at or above divisor cannot give a 32-bit quotient
    earlyNow = divZero || (!oddDest && dvdMag[63:32] >= rsMag);
  end

  assign accept         = start && (stateReg == ST_IDLE);
  assign divBus.start   = accept && !earlyNow;
  assign divBus.hiMag   = dvdMag[63:32];
  assign divBus.loMag   = dvdMag[31:0];
  assign divBus.divisor = rsMag;

  magnitude_divider divider (
    .clk   (clk),
    .rst_b (rst_b),
    .bus   (divBus)
  );

  // ************************************************************
  // Control and timing
  // ************************************************************
  logic [CNT_W-1:0] cntReg, cntNext;
  logic             oddReg, oddNext;
  logic             earlyReg, earlyNext;
  logic             slowReg, slowNext;
  logic             qNegReg, qNegNext;
  logic             remNegReg, remNegNext;
  logic             fileReg, fileNext;
  logic [IDX_W-1:0] idxReg, idxNext;
  logic [CNT_W-1:0] target;
  logic             finish;

  // Length of the run; minimum quotient takes 41 states, even or odd, and 44 with slowTiming
  always_comb begin
    if (earlyReg) begin
      target = STATES_EARLY;
    end else if (qNegReg && divBus.quotient == MIN_QUOTIENT) begin
      target = STATES_MINQ;
    end else if (oddReg) begin
      target = STATES_ODD;
    end else begin
      target = STATES_EVEN;
    end
    if (slowReg) begin
      target = target + SLOW_EXTRA;
    end
  end

  assign finish = (stateReg == ST_RUN) && (cntReg == target - 6'h01);

  // Operation context captured at issue
  always_comb begin
    stateNext  = stateReg;
    cntNext    = cntReg;
    oddNext    = oddReg;
    earlyNext  = earlyReg;
    slowNext   = slowReg;
    qNegNext   = qNegReg;
    remNegNext = remNegReg;
    fileNext   = fileReg;
    idxNext    = idxReg;
    case (stateReg)
      ST_IDLE: begin
        if (accept) begin
          stateNext  = ST_RUN;
          cntNext    = 6'h01;
          oddNext    = oddDest;
          earlyNext  = earlyNow;
          slowNext   = slowTiming;
          qNegNext   = dvdSign ^ srcValue[31];
          remNegNext = dvdSign;
          fileNext   = fileSel;
          idxNext    = destIndex;
        end
      end
      ST_RUN: begin
        cntNext = cntReg + 6'h01;
        if (finish) begin
          stateNext = ST_IDLE;
        end
      end
      default: begin
        stateNext = ST_IDLE;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stateReg  <= ST_IDLE;
      cntReg    <= CNT_RESET;
      oddReg    <= 1'b0;
      earlyReg  <= 1'b0;
      slowReg   <= 1'b0;
      qNegReg   <= 1'b0;
      remNegReg <= 1'b0;
      fileReg   <= 1'b0;
      idxReg    <= IDX_RESET;
    end else begin
      stateReg  <= stateNext;
      cntReg    <= cntNext;
      oddReg    <= oddNext;
      earlyReg  <= earlyNext;
      slowReg   <= slowNext;
      qNegReg   <= qNegNext;
      remNegReg <= remNegNext;
      fileReg   <= fileNext;
      idxReg    <= idxNext;
    end
  end

  assign busy = (stateReg != ST_IDLE);

  // ************************************************************
  // Results and flags
  // ************************************************************
  logic [31:0]      qSigned;
  logic [31:0]      remSigned;
  logic             fits;
  logic             ovf;
  logic             doneReg, doneNext;
  logic             wrEnReg, wrEnNext;
  logic             wr2EnReg, wr2EnNext;
  logic [31:0]      wrDataReg, wrDataNext;
  logic [31:0]      wr2DataReg, wr2DataNext;
  logic             nReg, nNext;
  logic             zReg, zNext;
  logic             vReg, vNext;
  logic [3:0]       maskReg, maskNext;

  // Sign restore and range check on the magnitude quotient
  always_comb begin
    qSigned   = qNegReg ? 32'(32'h0 - divBus.quotient) : divBus.quotient;
    remSigned = remNegReg ? 32'(32'h0 - divBus.remainder)
                          : divBus.remainder;
    if (qNegReg) begin
      fits = (divBus.quotient <= MIN_QUOTIENT);
    end else begin
      fits = !divBus.quotient[31];
    end
    ovf = earlyReg || !fits;
  end

  // Pulses last one cycle; data and flags hold until next finish
  always_comb begin
    doneNext    = finish;
    wrEnNext    = finish && !ovf;
    wr2EnNext   = finish && !ovf && !oddReg;
    wrDataNext  = wrDataReg;
    wr2DataNext = wr2DataReg;
    nNext       = nReg;
    zNext       = zReg;
    vNext       = vReg;
    maskNext    = maskReg;
    if (finish) begin
      if (!ovf) begin
        wrDataNext  = qSigned;
        wr2DataNext = oddReg ? wr2DataReg : remSigned;
      end
      nNext    = !ovf && qSigned[31];
      zNext    = !ovf && (qSigned == DATA_RESET);
      vNext    = ovf;
      maskNext = FLAG_WRITE_MASK;
    end
  end

  // Registers only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      doneReg    <= 1'b0;
      wrEnReg    <= 1'b0;
      wr2EnReg   <= 1'b0;
      wrDataReg  <= DATA_RESET;
      wr2DataReg <= DATA_RESET;
      nReg       <= 1'b0;
      zReg       <= 1'b0;
      vReg       <= 1'b0;
      maskReg    <= FLAG_MASK_RESET;
    end else begin
      doneReg    <= doneNext;
      wrEnReg    <= wrEnNext;
      wr2EnReg   <= wr2EnNext;
      wrDataReg  <= wrDataNext;
      wr2DataReg <= wr2DataNext;
      nReg       <= nNext;
      zReg       <= zNext;
      vReg       <= vNext;
      maskReg    <= maskNext;
    end
  end

  assign done          = doneReg;
  assign wrFile        = fileReg;
  assign wrEnable      = wrEnReg;
  assign wrIndex       = idxReg;
  assign wrData        = wrDataReg;
  assign wr2Enable     = wr2EnReg;
  assign wr2Index      = 4'(idxReg + 4'h1);
  assign wr2Data       = wr2DataReg;
  assign nFlag         = nReg;
  assign zFlag         = zReg;
  assign vFlag         = vReg;
  assign flagWriteMask = maskReg;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  AST_EVEN_TIME: assert property (
    accept && !earlyNow && !slowTiming && !oddDest |-> ##[40:41] done)
    else $error("even divide did not finish in 40 or 41 states");
  AST_ODD_TIME: assert property (
    accept && !earlyNow && !slowTiming && oddDest |->
      ##1 !done [*8] ##[31:33] done)
    else $error("odd divide did not finish in 39 to 41 states");
  AST_EARLY_TIME: assert property (
    accept && earlyNow && !slowTiming |-> ##7 done)
    else $error("early finish not at 7 states");
  AST_SLOW_EARLY: assert property (
    accept && earlyNow && slowTiming |-> ##10 done)
    else $error("slow early finish not at 10 states");
  AST_DIV_ZERO: assert property (
    accept && divZero |-> ##[7:10] (done && vFlag))
    else $error("divide by zero did not flag overflow");
  AST_NO_WRITE: assert property (
    done && vFlag |-> !wrEnable && !wr2Enable)
    else $error("register written on overflow");
  AST_ODD_WRITE: assert property (
    done && !vFlag && oddReg |-> wrEnable && !wr2Enable)
    else $error("odd divide wrote the wrong registers");
  AST_EVEN_WRITE: assert property (
    done && !vFlag && !oddReg |->
      wrEnable && wr2Enable && wr2Index == 4'(wrIndex + 4'h1))
    else $error("even divide wrote the wrong registers");
  AST_NEG_FLAG: assert property (
    done && !vFlag |-> nFlag == wrData[31] && !flagWriteMask[2])
    else $error("negative flag does not match quotient");
  AST_ZERO_FLAG: assert property (
    done && !vFlag |-> zFlag == (wrData == 32'h0000_0000))
    else $error("zero flag does not match quotient");
  AST_REM_SIGN: assert property (
    wr2Enable && wr2Data != 32'h0000_0000 |-> wr2Data[31] == remNegReg)
    else $error("remainder sign differs from dividend");
  AST_FILE_HOLD: assert property (
    accept |=> (wrFile == $past(fileSel)) && busy)
    else $error("result file differs from operand file");
  AST_DIV_SETTLED: assert property (
    finish && !earlyReg |-> !divBus.busy)
    else $error("finish before the divider settled");

  COV_EVEN: cover property (done && wr2Enable);
  COV_ODD: cover property (done && wrEnable && !wr2Enable);
  COV_EARLY: cover property (done && vFlag && earlyReg);
  COV_MINQ: cover property (done && wrEnable && wrData == MIN_QUOTIENT);

endmodule : signed_register_divider

`default_nettype wire

// ===== dv/signed_register_divider_test.sv
// Self-checking bench for the signed register divide unit.
// Assumes the package and the unit are compiled first; no partner model.
`default_nettype none

module signed_register_divider_test;
  timeunit 1ns;
  timeprecision 1ns;
  import signed_divide_pkg::*;

  // ************************************************************
  // Signals and vector table
  // ************************************************************
  logic                     clk;
  logic                     rst_b;
  logic                     start;
  logic [IDX_W-1:0]         destIndex;
  logic                     fileSel;
  logic                     slowTiming;
  logic [DATA_W-1:0]        destValue;
  logic [DATA_W-1:0]        destNextValue;
  logic [DATA_W-1:0]        srcValue;
  logic                     busy;
  logic                     done;
  logic                     wrFile;
  logic                     wrEnable;
  logic [IDX_W-1:0]         wrIndex;
  logic [DATA_W-1:0]        wrData;
  logic                     wr2Enable;
  logic [IDX_W-1:0]         wr2Index;
  logic [DATA_W-1:0]        wr2Data;
  logic                     nFlag;
  logic                     zFlag;
  logic                     vFlag;
  logic [3:0]               flagWriteMask;
  int                       n_mismatch;
  int                       checked;
  logic [31:0]              lastQ;

  typedef struct {
    logic [3:0]  idx;
    logic        fs;
    logic        slow;
    logic [31:0] dv, dn, sv, q, r;
    logic [2:0]  nzv;
    int          t;
  } vec_type;
  vec_type tbl[$];

  signed_register_divider i_dut (
    .clk(clk), .rst_b(rst_b), .start(start), .destIndex(destIndex),
    .fileSel(fileSel), .slowTiming(slowTiming), .destValue(destValue),
    .destNextValue(destNextValue), .srcValue(srcValue), .busy(busy),
    .done(done), .wrFile(wrFile), .wrEnable(wrEnable), .wrIndex(wrIndex),
    .wrData(wrData), .wr2Enable(wr2Enable), .wr2Index(wr2Index),
    .wr2Data(wr2Data), .nFlag(nFlag), .zFlag(zFlag), .vFlag(vFlag),
    .flagWriteMask(flagWriteMask)
  );

  // ************************************************************
  // Tasks
  // ************************************************************
  task add(input logic [3:0] idx, input logic fs, slow,
           input logic [31:0] dv, dn, sv, q, r,
           input logic [2:0] nzv, input int t);
    vec_type e;
    e = '{idx, fs, slow, dv, dn, sv, q, r, nzv, t};
    tbl.push_back(e);
  endtask : add

  task chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk

  task test_done;
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // Present an issue at the current falling edge
  task issue(input vec_type e);
    start = 1'b1;
    destIndex = e.idx;
    fileSel = e.fs;
    slowTiming = e.slow;
    destValue = e.dv;
    destNextValue = e.dn;
    srcValue = e.sv;
  endtask : issue

  // One operation; the next may be issued in this done cycle
  task run(input vec_type e, input bit poke);
    int   cnt;
    logic v;
    v = e.nzv[0];
    issue(e);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
      // Poke only mid-run, so it never meets the next issue
      if (cnt == 1 || (poke && cnt inside {[3:4]})) start = (cnt == 3);
      if (cnt == 1) begin
        destValue = ~e.dv; // Garbage: operands count only at issue
        srcValue = 32'h0;
        chk(done === 1'b0 && wrEnable === 1'b0 && wr2Enable === 1'b0,
            "pulse held");
      end
      if (cnt < e.t) chk(busy === 1'b1, "busy dropped early");
    end while (done !== 1'b1 && cnt < 60);
    if (done !== 1'b1) begin
      chk(1'b0, "done never came");
      test_done();
    end else begin
      chk(cnt == e.t, "wrong state count");
      chk(busy === 1'b0, "busy at done");
      chk(nFlag === e.nzv[2], "negative flag");
      chk(zFlag === e.nzv[1], "zero flag");
      chk(vFlag === v, "overflow flag");
      chk(flagWriteMask === 4'hB, "carry not preserved");
      chk(wrFile === e.fs, "file select");
      chk(wrIndex === e.idx, "quotient index");
      chk(wrEnable === !v, "quotient write");
      chk(wr2Enable === (!v && !e.idx[0]), "remainder write");
      chk(wrData === (v ? lastQ : e.q), "quotient");
      if (!v) lastQ = e.q;
      if (!v && !e.idx[0]) begin
        chk(wr2Index === e.idx + 4'h1, "remainder index");
        chk(wr2Data === e.r, "remainder");
      end
    end
  endtask : run

  // ************************************************************
  // Clock and main sequence
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    rst_b = 1'b0;
    start = 1'b0;
    destIndex = 4'h0;
    fileSel = 1'b0;
    slowTiming = 1'b0;
    destValue = 32'h0;
    destNextValue = 32'h0;
    srcValue = 32'h0;
    n_mismatch = 0;
    checked = 0;
    lastQ = 32'h0;
    // Even destinations: 64 by 32
    add(4'h0, 0, 0, 32'h12345678, 32'h87654321, 32'h87654321,
        32'hD95BC60A, 32'h15CA1DD7, 3'b100, 40);
    add(4'h2, 1, 1, 32'hEDCBA987, 32'h789ABCDF, 32'h87654321,
        32'h26A439F6, 32'hEA35E229, 3'b000, 43);
    add(4'h4, 0, 0, 32'hEDCBA987, 32'h789ABCDF, 32'h789ABCDF,
        32'hD95BC60A, 32'hEA35E229, 3'b100, 40);
    add(4'hE, 1, 0, 32'h12345678, 32'h87654321, 32'h789ABCDF,
        32'h26A439F6, 32'h15CA1DD7, 3'b000, 40);
    add(4'h6, 0, 0, 32'h12345678, 32'h87654321, 32'h0,
        32'h0, 32'h0, 3'b001, 7);
    add(4'h8, 0, 1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 3'b001, 10);
    add(4'hA, 0, 0, 32'h0, 32'h0, 32'h87654321,
        32'h0, 32'h0, 3'b010, 40);
    add(4'h0, 1, 0, 32'h87654321, 32'h0, 32'h87654321,
        32'h0, 32'h0, 3'b001, 7);
    add(4'hC, 1, 1, 32'hFFFFFFFF, 32'h0, 32'h2,
        32'h80000000, 32'h0, 3'b100, 44);
    // Odd destinations: 32 by 32, quotient only
    add(4'h1, 0, 0, 32'h87654321, 32'h0, 32'h12345678,
        32'hFFFFFFFA, 32'h0, 3'b100, 39);
    add(4'h3, 1, 0, 32'h87654321, 32'h0, 32'hEDCBA988,
        32'h6, 32'h0, 3'b000, 39);
    add(4'h5, 0, 1, 32'h789ABCDF, 32'h0, 32'hEDCBA988,
        32'hFFFFFFFA, 32'h0, 3'b100, 42);
    add(4'hF, 1, 0, 32'h789ABCDF, 32'h0, 32'h12345678,
        32'h6, 32'h0, 3'b000, 39);
    add(4'h7, 0, 1, 32'h87654321, 32'h0, 32'h0,
        32'h0, 32'h0, 3'b001, 10);
    add(4'h9, 0, 0, 32'h80000000, 32'h0, 32'h1,
        32'h80000000, 32'h0, 3'b100, 41);
    repeat (5) @(negedge clk);
    chk(busy === 1'b0 && done === 1'b0 && wrData === 32'h0, "reset state");
    rst_b = 1'b1;
    // Back to back: each issue after the first lands in the previous done cycle
    foreach (tbl[i]) run(tbl[i], i == 0);
    // Reset in mid-run, then a clean operation
    issue(tbl[0]);
    repeat (5) @(negedge clk) start = 1'b0;
    rst_b = 1'b0;
    @(negedge clk);
    chk(busy === 1'b0 && done === 1'b0 && wrData === 32'h0, "mid reset");
    rst_b = 1'b1;
    lastQ = 32'h0;
    run(tbl[0], 1'b0);
    test_done();
  end

endmodule : signed_register_divider_test

`default_nettype wire
